// File: logic/sspr_top.sv
// Synchronous serial port: register file on Avalon-MM, transmit and receive FIFOs, controller/target shifter.
// Assumes pin inputs are asynchronous to CLK; the pin wires are resolved from the enables outside.
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/100ps
module sspr_top #(
    parameter int unsigned FIFO_DEPTH = 8
) (
    input wire logic CLK, // Block clock, 10 MHz.
    input wire logic NRST, // Synchronous reset, active low.
    input wire logic CE, // Clock enable; all state holds while low.
    input wire logic [5:0] AVS_ADDRESS, // Byte address.
    input wire logic AVS_READ, // Read request.
    input wire logic AVS_WRITE, // Write request.
    input wire logic [31:0] AVS_WRITEDATA, // Write data.
    input wire logic [3:0] AVS_BYTEENABLE, // Byte lanes of a write.
    output logic [31:0] AVS_READDATA, // Read data.
    output logic AVS_WAITREQUEST, // Stall, high until the access completes.
    output logic IRQ, // Level interrupt, active high.
    input wire logic SCLK_I, // Serial clock pin level.
    output logic SCLK_O, // Serial clock driven as controller.
    output logic SCLK_OE, // Serial clock drive enable.
    input wire logic SEL_N_I, // Frame select pin level, active low.
    output logic SEL_N_O, // Frame select driven as controller, active low.
    output logic SEL_N_OE, // Frame select drive enable.
    output logic TXD_O, // Serial data out.
    output logic TXD_OE, // Serial data out drive enable.
    input wire logic RXD_I // Serial data in.
);
    localparam int unsigned CW = $clog2(FIFO_DEPTH) + 1;

    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 256) begin : g_bad_depth
        $error("FIFO_DEPTH must lie between 2 and 256");
    end

    typedef struct packed {
        logic wait_req;
        logic [31:0] rdata;
        logic [3:0] size_m1;
        logic role;
        logic enable;
        logic loop;
        logic [6:0] psc_half;
        logic [3:0] mask;
        logic tmo_pend;
        logic ovr_pend;
        logic irq;
        sspr_pkg::sspr_state_t fsm;
        logic [6:0] div;
        logic [4:0] bits_left;
        logic [15:0] tx_sh;
        logic [15:0] rx_sh;
        logic sclk;
        logic sel_n;
        logic txd;
        logic sclk_oe;
        logic sel_oe;
        logic txd_oe;
        logic [12:0] tmo_cnt;
        logic sclk_prev;
    } sspr_top_st_t;

    sspr_top_st_t st_ff;
    sspr_top_st_t nxt_st;

    logic [2:0] pin_sync;
    logic sclk_s;
    logic sel_n_s;
    logic rxd_s;
    logic tx_push;
    logic tx_pop;
    logic rx_push;
    logic rx_pop;
    logic [15:0] tx_head;
    logic [15:0] rx_head;
    logic [15:0] rx_word;
    logic [CW-1:0] tx_count;
    logic [CW-1:0] rx_count;
    logic tx_full;
    logic tx_empty;
    logic rx_full;
    logic rx_empty;
    logic [3:0] raw;
    logic busy;
    logic bus_start;
    logic bus_exec;
    logic [15:0] psc_w;

    function automatic logic [15:0] size_mask(input logic [3:0] size_m1);
        size_mask = 16'hffff >> (4'hf - size_m1);
    endfunction : size_mask

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : merge16

    sspr_sync #(
        .W(3)
    ) u_pin_sync (
        .clk(CLK),
        .nrst(NRST),
        .ce(CE),
        .d({SCLK_I, SEL_N_I, RXD_I}),
        .q(pin_sync)
    );

    assign sclk_s = pin_sync[2];
    assign sel_n_s = pin_sync[1];
    assign rxd_s = pin_sync[0];

    sspr_fifo #(
        .W(16),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk(CLK),
        .nrst(NRST),
        .ce(CE),
        .push(tx_push),
        .wdata(AVS_WRITEDATA[15:0]),
        .pop(tx_pop),
        .rdata(tx_head),
        .count(tx_count),
        .full(tx_full),
        .empty(tx_empty)
    );

    sspr_fifo #(
        .W(16),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .clk(CLK),
        .nrst(NRST),
        .ce(CE),
        .push(rx_push),
        .wdata(rx_word),
        .pop(rx_pop),
        .rdata(rx_head),
        .count(rx_count),
        .full(rx_full),
        .empty(rx_empty)
    );

    // An access is taken in two edges: the first latches read data, the second commits side effects.
    assign bus_start = (AVS_READ || AVS_WRITE) && st_ff.wait_req;
    assign bus_exec = (AVS_READ || AVS_WRITE) && !st_ff.wait_req;
    assign tx_push = bus_exec && AVS_WRITE && (AVS_ADDRESS == sspr_pkg::OFS_DATA) && AVS_BYTEENABLE[0];
    assign rx_pop = bus_exec && AVS_READ && (AVS_ADDRESS == sspr_pkg::OFS_DATA);
    assign rx_push = (st_ff.fsm == sspr_pkg::ST_DONE);
    assign psc_w = merge16({8'h00, st_ff.psc_half, 1'b0}, AVS_WRITEDATA, AVS_BYTEENABLE);
    assign rx_word = st_ff.rx_sh & size_mask(st_ff.size_m1);
    assign busy = (st_ff.fsm != sspr_pkg::ST_IDLE) || !tx_empty;
    assign tx_pop = st_ff.enable && (st_ff.fsm == sspr_pkg::ST_IDLE) && !tx_empty
        && (!st_ff.role || !sel_n_s);

    always_comb begin
        raw = '0;
        raw[sspr_pkg::IRQ_TX_LEVEL_BIT] = (tx_count <= CW'(FIFO_DEPTH / 2));
        raw[sspr_pkg::IRQ_RX_LEVEL_BIT] = (rx_count >= CW'(FIFO_DEPTH / 2));
        raw[sspr_pkg::IRQ_TIMEOUT_BIT] = st_ff.tmo_pend;
        raw[sspr_pkg::IRQ_OVERRUN_BIT] = st_ff.ovr_pend;
    end

    always_comb begin
        logic [31:0] rd;
        logic rx_bit;
        logic sclk_rise;
        logic sclk_fall;
        logic [15:0] shifted;
        logic [12:0] tmo_limit;
        logic [3:0] clr;
        rd = '0;
        rx_bit = 1'b0;
        sclk_rise = 1'b0;
        sclk_fall = 1'b0;
        shifted = '0;
        tmo_limit = '0;
        clr = '0;
        nxt_st = st_ff;

        // Register read data is captured at the first edge so a data-port pop sees the current head.
        if (AVS_ADDRESS == sspr_pkg::OFS_FRAME_CFG) begin
            rd[3:0] = st_ff.size_m1;
        end else if (AVS_ADDRESS == sspr_pkg::OFS_CONTROL) begin
            rd[sspr_pkg::CTL_ROLE_BIT] = st_ff.role;
            rd[sspr_pkg::CTL_ENABLE_BIT] = st_ff.enable;
            rd[sspr_pkg::CTL_RETURN_BIT] = st_ff.loop;
        end else if (AVS_ADDRESS == sspr_pkg::OFS_DATA) begin
            rd[15:0] = rx_empty ? 16'h0000 : rx_head;
        end else if (AVS_ADDRESS == sspr_pkg::OFS_STATUS) begin
            rd[sspr_pkg::STS_BUSY_BIT] = busy;
            rd[sspr_pkg::STS_RX_FULL_BIT] = rx_full;
            rd[sspr_pkg::STS_RX_NOT_EMPTY_BIT] = !rx_empty;
            rd[sspr_pkg::STS_TX_NOT_FULL_BIT] = !tx_full;
            rd[sspr_pkg::STS_TX_EMPTY_BIT] = tx_empty;
        end else if (AVS_ADDRESS == sspr_pkg::OFS_PRESCALE) begin
            rd[7:0] = {st_ff.psc_half, 1'b0};
        end else if (AVS_ADDRESS == sspr_pkg::OFS_IRQ_MASK) begin
            rd[3:0] = st_ff.mask;
        end else if (AVS_ADDRESS == sspr_pkg::OFS_IRQ_RAW) begin
            rd[3:0] = raw;
        end else if (AVS_ADDRESS == sspr_pkg::OFS_IRQ_MASKED) begin
            rd[3:0] = raw & st_ff.mask;
        end

        if (bus_start) begin
            nxt_st.wait_req = 1'b0;
            nxt_st.rdata = AVS_READ ? rd : 32'h0000_0000;
        end else if (bus_exec) begin
            nxt_st.wait_req = 1'b1;
        end

        // Writes commit at the edge where waitrequest is seen low; unmapped writes are dropped.
        if (bus_exec && AVS_WRITE && AVS_BYTEENABLE[0]) begin
            if (AVS_ADDRESS == sspr_pkg::OFS_FRAME_CFG) begin
                nxt_st.size_m1 = AVS_WRITEDATA[3:0];
            end else if (AVS_ADDRESS == sspr_pkg::OFS_CONTROL) begin
                // Role may change only while the port is disabled, so a running frame is never split.
                if (!st_ff.enable) begin
                    nxt_st.role = AVS_WRITEDATA[sspr_pkg::CTL_ROLE_BIT];
                end
                nxt_st.enable = AVS_WRITEDATA[sspr_pkg::CTL_ENABLE_BIT];
                nxt_st.loop = AVS_WRITEDATA[sspr_pkg::CTL_RETURN_BIT];
            end else if (AVS_ADDRESS == sspr_pkg::OFS_PRESCALE) begin
                nxt_st.psc_half = psc_w[7:1];
            end else if (AVS_ADDRESS == sspr_pkg::OFS_IRQ_MASK) begin
                nxt_st.mask = AVS_WRITEDATA[3:0];
            end else if (AVS_ADDRESS == sspr_pkg::OFS_IRQ_CLEAR) begin
                clr = AVS_WRITEDATA[3:0];
            end
        end

        // Latched conditions: a new event in the clearing cycle keeps the flag set.
        if (clr[sspr_pkg::IRQ_OVERRUN_BIT]) begin
            nxt_st.ovr_pend = 1'b0;
        end
        if (clr[sspr_pkg::IRQ_TIMEOUT_BIT]) begin
            nxt_st.tmo_pend = 1'b0;
        end
        if (rx_push && rx_full && !rx_pop) begin
            nxt_st.ovr_pend = 1'b1;
        end

        // Timeout runs a fixed number of bit periods of unread receive data.
        tmo_limit = {st_ff.psc_half, 1'b0, 5'b00000} << (sspr_pkg::TIMEOUT_SHIFT - 5);
        if (rx_empty || rx_pop || rx_push || !st_ff.enable) begin
            nxt_st.tmo_cnt = '0;
        end else if (st_ff.tmo_cnt >= tmo_limit) begin
            nxt_st.tmo_pend = 1'b1;
        end else begin
            nxt_st.tmo_cnt = st_ff.tmo_cnt + 13'h0001;
        end

        nxt_st.irq = |(raw & st_ff.mask);

        // Return path feeds the transmit bit straight back to the receive shifter.
        rx_bit = st_ff.loop ? st_ff.txd : rxd_s;
        nxt_st.sclk_prev = sclk_s;
        sclk_rise = st_ff.role && sclk_s && !st_ff.sclk_prev;
        sclk_fall = st_ff.role && !sclk_s && st_ff.sclk_prev;
        shifted = st_ff.tx_sh << 1;

        case (st_ff.fsm)
            sspr_pkg::ST_IDLE: begin
                nxt_st.sclk = 1'b0;
                nxt_st.sel_n = 1'b1;
                if (st_ff.enable && (!st_ff.role || !sel_n_s) && (st_ff.role || !tx_empty)) begin
                    nxt_st.tx_sh = tx_empty ? 16'h0000 : (tx_head & size_mask(st_ff.size_m1));
                    nxt_st.txd = nxt_st.tx_sh[st_ff.size_m1];
                    nxt_st.bits_left = 5'(st_ff.size_m1) + 5'h01;
                    nxt_st.div = (st_ff.psc_half == 7'h00) ? 7'h01 : st_ff.psc_half;
                    nxt_st.sel_n = st_ff.role;
                    nxt_st.fsm = sspr_pkg::ST_SHIFT;
                end
            end
            sspr_pkg::ST_SHIFT: begin
                if (!st_ff.role) begin
                    if (st_ff.div > 7'h01) begin
                        nxt_st.div = st_ff.div - 7'h01;
                    end else begin
                        nxt_st.div = (st_ff.psc_half == 7'h00) ? 7'h01 : st_ff.psc_half;
                        sclk_rise = !st_ff.sclk;
                        sclk_fall = st_ff.sclk;
                        nxt_st.sclk = !st_ff.sclk;
                    end
                end
                if (sclk_rise) begin
                    nxt_st.rx_sh = {st_ff.rx_sh[14:0], rx_bit};
                    nxt_st.bits_left = st_ff.bits_left - 5'h01;
                end
                if (sclk_fall) begin
                    if (st_ff.bits_left == 5'h00) begin
                        nxt_st.fsm = sspr_pkg::ST_DONE;
                    end else begin
                        nxt_st.tx_sh = shifted;
                        nxt_st.txd = shifted[st_ff.size_m1];
                    end
                end
                if (st_ff.role && sel_n_s) begin
                    nxt_st.fsm = sspr_pkg::ST_IDLE;
                end
            end
            sspr_pkg::ST_DONE: begin
                nxt_st.sel_n = 1'b1;
                nxt_st.fsm = sspr_pkg::ST_IDLE;
            end
            default: begin
                nxt_st.fsm = sspr_pkg::ST_IDLE;
            end
        endcase

        if (!st_ff.enable) begin
            nxt_st.fsm = sspr_pkg::ST_IDLE;
            nxt_st.sel_n = 1'b1;
            nxt_st.sclk = 1'b0;
        end

        // Pins are left undriven while disabled or looped back, and by a target that is not selected.
        nxt_st.sclk_oe = nxt_st.enable && !nxt_st.role && !nxt_st.loop;
        nxt_st.sel_oe = nxt_st.sclk_oe;
        nxt_st.txd_oe = nxt_st.enable && !nxt_st.loop && (!nxt_st.role || (nxt_st.fsm != sspr_pkg::ST_IDLE));
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            st_ff <= '0;
            st_ff.wait_req <= 1'b1;
            st_ff.size_m1 <= sspr_pkg::RST_FRAME_SIZE_M1;
            st_ff.psc_half <= sspr_pkg::RST_PRESCALE[7:1];
            st_ff.mask <= sspr_pkg::RST_IRQ_MASK;
            st_ff.fsm <= sspr_pkg::ST_IDLE;
            st_ff.sel_n <= 1'b1;
        end else if (CE) begin
            st_ff <= nxt_st;
        end
    end

    assign AVS_READDATA = st_ff.rdata;
    assign AVS_WAITREQUEST = st_ff.wait_req;
    assign IRQ = st_ff.irq;
    assign SCLK_O = st_ff.sclk;
    assign SCLK_OE = st_ff.sclk_oe;
    assign SEL_N_O = st_ff.sel_n;
    assign SEL_N_OE = st_ff.sel_oe;
    assign TXD_O = st_ff.txd;
    assign TXD_OE = st_ff.txd_oe;

endmodule : sspr_top

// File: inc/sspr_pkg.sv
// Shared constants for the synchronous serial port: register offsets, field positions, reset values, timing.
// Assumes byte addressing on a 32-bit Avalon-MM slave with one register per aligned word.
package sspr_pkg;

    localparam int unsigned ADDR_W = 6;
    localparam logic [5:0] OFS_FRAME_CFG = 6'h00;
    localparam logic [5:0] OFS_CONTROL = 6'h04;
    localparam logic [5:0] OFS_DATA = 6'h08;
    localparam logic [5:0] OFS_STATUS = 6'h0c;
    localparam logic [5:0] OFS_PRESCALE = 6'h10;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h14;
    localparam logic [5:0] OFS_IRQ_RAW = 6'h18;
    localparam logic [5:0] OFS_IRQ_MASKED = 6'h1c;
    localparam logic [5:0] OFS_IRQ_CLEAR = 6'h20;

    // Control word fields.
    localparam int unsigned CTL_ROLE_BIT = 2;
    localparam int unsigned CTL_ENABLE_BIT = 1;
    localparam int unsigned CTL_RETURN_BIT = 0;

    // Status word fields.
    localparam int unsigned STS_BUSY_BIT = 4;
    localparam int unsigned STS_RX_FULL_BIT = 3;
    localparam int unsigned STS_RX_NOT_EMPTY_BIT = 2;
    localparam int unsigned STS_TX_NOT_FULL_BIT = 1;
    localparam int unsigned STS_TX_EMPTY_BIT = 0;

    // Interrupt word fields, shared by mask, raw, masked and clear views.
    localparam int unsigned IRQ_TX_LEVEL_BIT = 3;
    localparam int unsigned IRQ_RX_LEVEL_BIT = 2;
    localparam int unsigned IRQ_TIMEOUT_BIT = 1;
    localparam int unsigned IRQ_OVERRUN_BIT = 0;

    localparam logic [3:0] RST_FRAME_SIZE_M1 = 4'h7;
    localparam logic [7:0] RST_PRESCALE = 8'h00;
    localparam logic [3:0] RST_IRQ_MASK = 4'h0;
    localparam logic [31:0] RST_STATUS = 32'h0000_0003;
    localparam logic [31:0] RST_IRQ_RAW = 32'h0000_0008;

    // Receive timeout length, in serial bit periods.
    localparam int unsigned TIMEOUT_BITS = 32;
    localparam int unsigned TIMEOUT_SHIFT = $clog2(TIMEOUT_BITS);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_DONE = 2'b10
    } sspr_state_t;

endpackage : sspr_pkg

// File: logic/sspr_sync.sv
// Two-flop synchroniser for pin inputs of the serial port.
// Assumes the inputs are asynchronous to CLK; only the second stage is read outside.
`timescale 1ns/100ps
module sspr_sync #(
    parameter int unsigned W = 1
) (
    input wire logic clk, // Block clock.
    input wire logic nrst, // Synchronous reset, active low.
    input wire logic ce, // Clock enable.
    input wire logic [W-1:0] d, // Asynchronous input.
    output logic [W-1:0] q // Synchronised output.
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sspr_sync_st_t;

    sspr_sync_st_t st_ff;
    sspr_sync_st_t nxt_st;

    always_comb begin
        nxt_st.s1 = d;
        nxt_st.s2 = st_ff.s1;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.s2;

endmodule : sspr_sync

// File: logic/sspr_fifo.sv
// Small synchronous FIFO whose head word is always held in a register.
// Push is ignored when full unless a pop comes in the same cycle; pop is ignored when empty.
`timescale 1ns/100ps
module sspr_fifo #(
    parameter int unsigned W = 16,
    parameter int unsigned DEPTH = 8
) (
    input wire logic clk, // Block clock.
    input wire logic nrst, // Synchronous reset, active low.
    input wire logic ce, // Clock enable.
    input wire logic push, // Write one word.
    input wire logic [W-1:0] wdata, // Word to write.
    input wire logic pop, // Drop the head word.
    output logic [W-1:0] rdata, // Head word, valid when not empty.
    output logic [$clog2(DEPTH):0] count, // Words held.
    output logic full, // No room.
    output logic empty // Nothing held.
);
    localparam int unsigned AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin : g_bad_param
        $error("FIFO depth must be a power of two of at least two");
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic [W-1:0] head;
    } sspr_fifo_st_t;

    sspr_fifo_st_t st_ff;
    sspr_fifo_st_t nxt_st;

    always_comb begin
        logic do_pop;
        logic do_push;
        do_pop = pop && (st_ff.cnt != '0);
        do_push = push && ((st_ff.cnt != (AW+1)'(DEPTH)) || do_pop);
        nxt_st = st_ff;
        if (do_push) begin
            nxt_st.mem[st_ff.wp] = wdata;
            nxt_st.wp = st_ff.wp + 1'b1;
        end
        if (do_pop) begin
            nxt_st.rp = st_ff.rp + 1'b1;
        end
        nxt_st.cnt = st_ff.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
        // Reading from the updated image covers a push into the head slot.
        nxt_st.head = nxt_st.mem[nxt_st.rp];
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign rdata = st_ff.head;
    assign count = st_ff.cnt;
    assign full = (st_ff.cnt == (AW+1)'(DEPTH));
    assign empty = (st_ff.cnt == '0);

endmodule : sspr_fifo

// File: test/sspr_sva.sv
// Checker for the serial port's register bus and controller pins.
// Bound to sspr_top below; sees only its ports.
`timescale 1ns/100ps
module sspr_sva (
    input wire logic CLK, // Block clock.
    input wire logic NRST, // Reset, active low.
    input wire logic [5:0] AVS_ADDRESS, // Byte address.
    input wire logic AVS_READ, // Read request.
    input wire logic AVS_WRITE, // Write request.
    input wire logic [31:0] AVS_READDATA, // Read data.
    input wire logic AVS_WAITREQUEST, // Stall.
    input wire logic SCLK_O, // Serial clock out.
    input wire logic SCLK_OE, // Clock drive enable.
    input wire logic SEL_N_O, // Select out, active low.
    input wire logic SEL_N_OE // Select drive enable.
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    sequence req_taken;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
    endsequence
    sequence rd_at(logic [5:0] a);
        AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS == a;
    endsequence
    req_answer_a: assert property (req_taken |=> !AVS_WAITREQUEST) else $error("no answer");
    wait_single_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("long ack");
    data_stands_a: assert property (!AVS_WAITREQUEST |=> $stable(AVS_READDATA)) else $error("data moved");
    data_width_a: assert property (rd_at(6'h08) |=> AVS_READDATA[31:16] == 16'h0) else $error("data wide");
    status_bits_a: assert property (rd_at(6'h0c) |=> AVS_READDATA[31:5] == 27'h0) else $error("status wide");
    busy_tx_a: assert property (rd_at(6'h0c) ##1 !AVS_READDATA[0] |-> AVS_READDATA[4]) else $error("not busy");
    psc_even_a: assert property (rd_at(6'h10) |=> AVS_READDATA[31:0] < 32'h100 && !AVS_READDATA[0])
        else $error("odd prescale");
    raw_width_a: assert property (rd_at(6'h18) |=> AVS_READDATA[31:4] == 28'h0) else $error("raw wide");
    masked_width_a: assert property (rd_at(6'h1c) |=> AVS_READDATA[31:4] == 28'h0) else $error("masked wide");
    idle_clock_a: assert property (SEL_N_O |-> !SCLK_O) else $error("clock outside frame");
    oe_pair_a: assert property (SEL_N_OE == SCLK_OE) else $error("enables differ");
endmodule : sspr_sva
bind sspr_top sspr_sva u_sva (.CLK(CLK), .NRST(NRST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .SCLK_O(SCLK_O),
    .SCLK_OE(SCLK_OE), .SEL_N_O(SEL_N_O), .SEL_N_OE(SEL_N_OE));

// File: test/sspr_peer.sv
// Serial peripheral model on the far side of the controller link, mode 0, MSB first.
// Assumes resolved pins: select idles high, clock idles low.
`timescale 1ns/100ps
module sspr_peer (
    input wire logic sclk, // Serial clock.
    input wire logic sel_n, // Select, active low.
    input wire logic mosi, // Data from the port.
    input wire logic [7:0] reply, // Word to return.
    output logic miso, // Data to the port.
    output logic [7:0] got // Last word received.
);
    logic [7:0] sh = 8'h00;
    initial miso = 1'b0;
    initial got = 8'h00;
    always @(negedge sel_n) begin
        sh = reply;
        miso = reply[7];
    end
    always @(posedge sclk) if (!sel_n) got = {got[6:0], mosi};
    always @(negedge sclk) if (!sel_n) begin
        sh = {sh[6:0], 1'b0};
        miso = sh[7];
    end
    // A released line must not keep its last bit, or a late sample would pass by luck.
    always @(posedge sel_n) miso = ~miso;
endmodule : sspr_peer

// File: test/tb_top.sv
// Bench for the serial port: registers over Avalon-MM, internal_return_path traffic and a peer device.
// Assumes the peer model sspr_peer and the bound checker sspr_sva.
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [5:0] addr = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, q;
    logic wait_req, irq, sclk, sclk_oe, sel_n, sel_oe, txd, txd_oe, rxd;
    logic [7:0] got;
    logic sclk_pin = 1'b0;
    logic sel_pin = 1'b1;
    int errors = 0;
    int total_checks = 0;
    always #50 clk = ~clk;
    sspr_top uut (.CLK(clk), .NRST(nrst), .CE(1'b1), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
        .IRQ(irq), .SCLK_I(sclk_pin), .SCLK_O(sclk), .SCLK_OE(sclk_oe), .SEL_N_I(sel_pin), .SEL_N_O(sel_n),
        .SEL_N_OE(sel_oe), .TXD_O(txd), .TXD_OE(txd_oe), .RXD_I(rxd));
    sspr_peer peer (.sclk(sclk_oe ? sclk : 1'b0), .sel_n(sel_oe ? sel_n : 1'b1), .mosi(txd_oe ? txd : 1'b1),
        .reply(8'h3c), .miso(rxd), .got(got));
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("FAIL t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // The request is held until waitrequest is seen low at an edge, for at most 20 edges before the run is ended.
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (wait_req !== 1'b0 && k < 20);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        if (k >= 20) begin
            errors++;
            complete_run();
        end
    endtask : bus
    task automatic rc(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rc
    task automatic idle;
        int k;
        k = 0;
        do begin
            bus(1'b0, 6'h0c, 32'h0);
            k++;
        end while (q[4] !== 1'b0 && k < 300);
        if (k >= 300) begin
            errors++;
            complete_run();
        end
    endtask : idle
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rc(6'h0c, 32'h3);
        rc(6'h18, 32'h8);
        rc(6'h10, 32'h0);
        rc(6'h14, 32'h0);
        rc(6'h1c, 32'h0);
        rc(6'h04, 32'h0);
        rc(6'h08, 32'h0);
        rc(6'h24, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 6'h14, 32'h1 << i);
            rc(6'h14, 32'h1 << i);
            rc(6'h1c, (32'h1 << i) & 32'h8);
            chk({31'h0, irq}, {31'h0, i == 3});
        end
        bus(1'b1, 6'h18, 32'h0);
        rc(6'h18, 32'h8);
        bus(1'b1, 6'h14, 32'h0);
        rc(6'h1c, 32'h0);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, 6'h10, 32'hff);
        rc(6'h10, 32'hfe);
        bus(1'b1, 6'h10, 32'h2);
        $display("test masks done");
        bus(1'b1, 6'h04, 32'h3);
        bus(1'b1, 6'h08, 32'h1a5);
        bus(1'b0, 6'h0c, 32'h0);
        chk(q & 32'h10, 32'h10);
        idle();
        rc(6'h0c, 32'h7);
        rc(6'h08, 32'ha5);
        rc(6'h0c, 32'h3);
        bus(1'b1, 6'h14, 32'hf);
        for (int i = 0; i < 9; i++) bus(1'b1, 6'h08, i);
        idle();
        repeat (100) @(posedge clk);
        rc(6'h0c, 32'hf);
        rc(6'h18, 32'hf);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, 6'h20, 32'h1);
        rc(6'h18, 32'he);
        rc(6'h08, 32'h0);
        bus(1'b1, 6'h20, 32'h2);
        rc(6'h18, 32'hc);
        for (int i = 1; i < 8; i++) rc(6'h08, i);
        rc(6'h1c, 32'h8);
        rc(6'h0c, 32'h3);
        $display("test internal_return_path done");
        bus(1'b1, 6'h14, 32'h0);
        bus(1'b1, 6'h10, 32'h8);
        bus(1'b1, 6'h04, 32'h2);
        bus(1'b1, 6'h08, 32'h96);
        idle();
        rc(6'h08, 32'h3c);
        chk({24'h0, got}, 32'h96);
        bus(1'b1, 6'h04, 32'h0);
        bus(1'b1, 6'h08, 32'h55);
        repeat (100) @(posedge clk);
        rc(6'h0c, 32'h12);
        chk({31'h0, sel_n}, 32'h1);
        bus(1'b1, 6'h04, 32'h4);
        rc(6'h04, 32'h4);
        $display("test link done");
        // Target with return path: the bench acts as controller with an 800 ns link clock.
        bus(1'b1, 6'h04, 32'h7);
        sel_pin <= 1'b0;
        repeat (8) @(posedge clk);
        for (int i = 0; i < 16; i++) begin
            sclk_pin <= ~sclk_pin;
            repeat (4) @(posedge clk);
        end
        repeat (4) @(posedge clk);
        sel_pin <= 1'b1;
        rc(6'h08, 32'h55);
        rc(6'h0c, 32'h3);
        $display("test target done");
        complete_run();
    end
endmodule : tb_top
